/* hdl/alrm_monitor.v */
// Notes on behaviour
// - Monitor off at reset; enable bit holds it.
// - Unreliable link forces 2.5 Gbps, drops 5.0 advertisement.
// - Downgrade holds until Detect or retrain at 5.0.
// - Partner upgrade request: enter Recovery, stay 2.5.
// - Count LCRC errors or Recovery entries, by type.
// - Threshold errors within period means unreliable.
// - Period counted in microseconds from core clock.
// - Detection sets unreliable-link-detected status.
// - Monitor downgrade sets bandwidth status, downstream only.
// - Error and period counts readable by software.
// - Period end restarts both counts.
// - Full retrain or retrain bit clears both counts; the code keeps frozen counts.
// - Counts freeze after detection.
// - Autonomous speed disable bit ignored by monitor.
// - Bandwidth status with enable sends interrupt upstream.
// - Status set by hardware, cleared only by software.
// - Counts run while disabled; status needs enable.
// - Frozen error count equals threshold at detection.
// - Only locally initiated Recovery entries counted.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "alrm_defs.vh"

module alrm_monitor #(
    parameter CNT_W = 16,
    parameter US_CYCLES = `ALRM_US_CYCLES,
    parameter DOWNSTREAM = 1
) (
    // Clock, reset and enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Link events from the LTSSM and data-link layer
    input wire lcrc_error,
    input wire recovery_entry_local,
    input wire partner_upgrade_req,
    input wire full_retrain,
    // Speed control towards the LTSSM
    output reg force_gen1,
    output reg advertise_gen2,
    output reg enter_recovery,
    output reg retrain_req,
    output reg bw_irq
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg enable;
    reg err_type;
    reg [CNT_W-1:0] error_threshold;
    reg [CNT_W-1:0] period;
    reg unreliable_link_detected;
    reg [CNT_W-1:0] error_count;
    reg [CNT_W-1:0] period_count;
    reg bandwidth_mgmt_irq_enable;
    reg bandwidth_mgmt_status;
    reg target_gen2;
    reg hw_autonomous_speed_disable;
    reg downgraded;
    reg [6:0] us_div;
    reg event_sel;
    reg next_force_gen1;
    reg next_advertise_gen2;
    reg next_enter_recovery;
    reg next_retrain_req;
    reg next_bw_irq;
    reg [31:0] next_prdata;
    wire hold_gen1;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire wr = psel && penable && pwrite;
    wire setup = psel && !penable;
    wire sel_ctrl = (paddr == `ALRM_CTRL_ADDR);
    wire sel_thr = (paddr == `ALRM_THR_ADDR);
    wire sel_sts = (paddr == `ALRM_STS_ADDR);
    wire sel_cnt = (paddr == `ALRM_CNT_ADDR);
    wire sel_lctl = (paddr == `ALRM_LCTL_ADDR);
    wire sel_lsts = (paddr == `ALRM_LSTS_ADDR);
    wire sel_lctl2 = (paddr == `ALRM_LCTL2_ADDR);
    // Unmapped offsets answer with an error and leave every register alone.
    wire rd_ok = sel_ctrl || sel_thr || sel_sts || sel_cnt || sel_lctl || sel_lsts || sel_lctl2;
    wire wr_ctrl = wr && sel_ctrl;
    wire wr_thr = wr && sel_thr;
    wire wr_sts = wr && sel_sts;
    wire wr_lctl = wr && sel_lctl;
    wire wr_lsts = wr && sel_lsts;
    wire wr_lctl2 = wr && sel_lctl2;
    wire sw_retrain = wr_lctl && pwdata[`ALRM_LCTL_RETRAIN_BIT];

    // ----------------------------------------------------------------
    // Event selection and detection
    // ----------------------------------------------------------------
    wire us_tick = (us_div == US_CYCLES - 1);
    // A retrain while the target is 2.5 Gbps leaves the downgrade standing.
    wire release_dg = full_retrain || (sw_retrain && target_gen2);
    wire count_clear = full_retrain || sw_retrain;
    always @* begin
        case (err_type)
            `ALRM_TYPE_RECOVERY: begin
                event_sel = recovery_entry_local;
            end
            default: begin
                event_sel = lcrc_error;
            end
        endcase
    end
    wire [CNT_W-1:0] next_error_count = error_count + {{(CNT_W-1){1'b0}}, event_sel};
    // Detection compares the count after this event, so the frozen value equals the threshold.
    wire hit = event_sel && (next_error_count == error_threshold) && (error_threshold != 0);
    wire detect = enable && !unreliable_link_detected && hit;
    wire frozen = unreliable_link_detected;
    wire period_end = us_tick && (period_count + 1'b1 >= period) && (period != 0);
    wire sts_clr = wr_sts && pwdata[`ALRM_STS_ULD_BIT];
    wire bw_clr = wr_lsts && pwdata[`ALRM_LSTS_BWSTS_BIT];

    // ----------------------------------------------------------------
    // Next values towards the LTSSM
    // ----------------------------------------------------------------
    // The downgrade reaches the pins one cycle after detection, not two.
    assign hold_gen1 = (downgraded || detect) && !release_dg;
    always @* begin
        next_force_gen1 = hold_gen1;
        next_advertise_gen2 = target_gen2 && !hold_gen1;
        next_enter_recovery = partner_upgrade_req || sw_retrain;
        next_retrain_req = sw_retrain;
        next_bw_irq = 1'b0;
        if (bandwidth_mgmt_irq_enable) begin
            if (bandwidth_mgmt_status || (detect && DOWNSTREAM != 0)) begin
                next_bw_irq = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `ALRM_CTRL_ADDR: begin
                next_prdata = {30'h0, err_type, enable};
            end
            `ALRM_THR_ADDR: begin
                next_prdata = {period, error_threshold};
            end
            `ALRM_STS_ADDR: begin
                next_prdata = {31'h0, unreliable_link_detected};
            end
            `ALRM_CNT_ADDR: begin
                next_prdata = {period_count, error_count};
            end
            `ALRM_LCTL_ADDR: begin
                next_prdata = {30'h0, bandwidth_mgmt_irq_enable, 1'b0};
            end
            `ALRM_LSTS_ADDR: begin
                next_prdata = {30'h0, force_gen1, bandwidth_mgmt_status};
            end
            `ALRM_LCTL2_ADDR: begin
                next_prdata = {30'h0, hw_autonomous_speed_disable, target_gen2};
            end
            default: begin
                next_prdata = 32'h00000000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Microsecond time base
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_div <= 7'h00;
        end else if (clk_en) begin
            if (us_tick || count_clear) begin
                us_div <= 7'h00;
            end else begin
                us_div <= us_div + 7'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Counters and detection
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_count <= {CNT_W{1'b0}};
            period_count <= {CNT_W{1'b0}};
            unreliable_link_detected <= 1'b0;
            downgraded <= 1'b0;
            bandwidth_mgmt_status <= 1'b0;
        end else if (clk_en) begin
            if (count_clear && !frozen) begin
                error_count <= {CNT_W{1'b0}};
                period_count <= {CNT_W{1'b0}};
            end else if (!frozen && !detect) begin
                if (period_end) begin
                    error_count <= {CNT_W{1'b0}};
                    period_count <= {CNT_W{1'b0}};
                end else begin
                    error_count <= next_error_count;
                    if (us_tick) begin
                        period_count <= period_count + 1'b1;
                    end
                end
            end else if (detect) begin
                error_count <= next_error_count;
            end
            // Set beats the software clear in the same cycle.
            if (detect) begin
                unreliable_link_detected <= 1'b1;
            end else if (sts_clr) begin
                unreliable_link_detected <= 1'b0;
            end
            // The speed disable bit is deliberately not consulted here.
            if (detect) begin
                downgraded <= 1'b1;
            end else if (release_dg) begin
                downgraded <= 1'b0;
            end
            if (detect && DOWNSTREAM != 0) begin
                bandwidth_mgmt_status <= 1'b1;
            end else if (bw_clr) begin
                bandwidth_mgmt_status <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers and LTSSM outputs
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 1'b0;
            err_type <= `ALRM_TYPE_LCRC;
            error_threshold <= `ALRM_THR_RESET;
            period <= `ALRM_PERIOD_RESET;
            bandwidth_mgmt_irq_enable <= 1'b0;
            target_gen2 <= `ALRM_TGT5_RESET;
            hw_autonomous_speed_disable <= 1'b0;
            force_gen1 <= 1'b0;
            advertise_gen2 <= 1'b1;
            enter_recovery <= 1'b0;
            retrain_req <= 1'b0;
            bw_irq <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                enable <= pwdata[`ALRM_CTRL_EN_BIT];
                err_type <= pwdata[`ALRM_CTRL_TYPE_BIT];
            end
            if (wr_thr) begin
                error_threshold <= pwdata[CNT_W-1:0];
                period <= pwdata[CNT_W+15:16];
            end
            if (wr_lctl) begin
                bandwidth_mgmt_irq_enable <= pwdata[`ALRM_LCTL_IRQEN_BIT];
            end
            if (wr_lctl2) begin
                target_gen2 <= pwdata[`ALRM_LCTL2_TGT5_BIT];
                hw_autonomous_speed_disable <= pwdata[`ALRM_LCTL2_HW_AUTONOMOUS_SPEED_DISABLE_BIT];
            end
            force_gen1 <= next_force_gen1;
            advertise_gen2 <= next_advertise_gen2;
            // The partner's upgrade request still takes the link through Recovery.
            enter_recovery <= next_enter_recovery;
            retrain_req <= next_retrain_req;
            bw_irq <= next_bw_irq;
        end
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= setup;
            pslverr <= setup && !rd_ok;
            prdata <= 32'h00000000;
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

endmodule

/* hdl/alrm_defs.vh */
`ifndef ALRM_DEFS_VH
`define ALRM_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ALRM_CTRL_ADDR 12'h000
`define ALRM_THR_ADDR 12'h004
`define ALRM_STS_ADDR 12'h008
`define ALRM_CNT_ADDR 12'h00C
`define ALRM_LCTL_ADDR 12'h010
`define ALRM_LSTS_ADDR 12'h014
`define ALRM_LCTL2_ADDR 12'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ALRM_CTRL_EN_BIT 0
`define ALRM_CTRL_TYPE_BIT 1
`define ALRM_STS_ULD_BIT 0
`define ALRM_LCTL_RETRAIN_BIT 0
`define ALRM_LCTL_IRQEN_BIT 1
`define ALRM_LSTS_BWSTS_BIT 0
`define ALRM_LSTS_GEN1_BIT 1
`define ALRM_LCTL2_TGT5_BIT 0
`define ALRM_LCTL2_HW_AUTONOMOUS_SPEED_DISABLE_BIT 1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ALRM_TYPE_LCRC 1'b0
`define ALRM_TYPE_RECOVERY 1'b1
`define ALRM_THR_RESET 16'h0000
`define ALRM_PERIOD_RESET 16'h0000
`define ALRM_TGT5_RESET 1'b1
`define ALRM_US_NS 1000
`define ALRM_CLK_NS 10
`define ALRM_US_CYCLES (`ALRM_US_NS / `ALRM_CLK_NS)

`endif

/* tb/alrm_checker.sv */
`timescale 1ns/1ps
module alrm_checker (
    // APB side
    input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Link side
    input wire lcrc_error, recovery_entry_local, partner_upgrade_req, full_retrain,
    input wire force_gen1, advertise_gen2, enter_recovery, retrain_req
);
    // Written for clk_en held high; a stalled clock enable would break the timing here.
    wire lwr = psel && penable && pwrite && paddr == 12'h010 && pwdata[0];
    wire ev = lcrc_error || recovery_entry_local;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (psel && !penable |=> pready) else $error("late");
    a_ready_once: assert property (pready |=> !pready) else $error("held");
    a_err_pair: assert property (pslverr |-> pready) else $error("slverr");
    a_gen1_adv: assert property (force_gen1 |-> !advertise_gen2) else $error("adv");
    a_gen1_hold: assert property (force_gen1 && !lwr && !full_retrain
        && !$past(lwr) && !$past(full_retrain) |=> force_gen1) else $error("hold");
    a_up_keep: assert property (force_gen1 && partner_upgrade_req && !full_retrain
        && !lwr |=> enter_recovery && force_gen1) else $error("up");
    a_gen1_cause: assert property ($rose(force_gen1) |-> $past(ev))
        else $error("cause");
    a_retrain_req: assert property (lwr |=> retrain_req) else $error("retrain");
endmodule
bind alrm_monitor alrm_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .pwdata(pwdata), .lcrc_error(lcrc_error), .recovery_entry_local(recovery_entry_local),
    .partner_upgrade_req(partner_upgrade_req), .full_retrain(full_retrain),
    .force_gen1(force_gen1), .advertise_gen2(advertise_gen2),
    .enter_recovery(enter_recovery), .retrain_req(retrain_req));

/* tb/alrm_link_model.sv */
`timescale 1ns/1ps
module alrm_link_model (
    input wire pclk,
    output wire lcrc_error,
    output wire recovery_entry_local,
    output wire partner_upgrade_req,
    output wire full_retrain
);
    reg [3:0] ev = 4'h0;
    // Partner-started entries reach the port only as upgrade requests.
    assign {full_retrain, partner_upgrade_req,
        recovery_entry_local, lcrc_error} = ev;
    // Kinds: 0 LCRC, 1 local Recovery, 2 partner upgrade, 3 Detect pass.
    task send(input [1:0] k, input [3:0] n, input [7:0] gap);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            @(posedge pclk);
            ev <= 4'h1 << k;
            @(posedge pclk);
            ev <= 4'h0;
            repeat (gap) @(posedge pclk);
        end
    endtask
endmodule

/* tb/test_alrm_monitor.sv */
`timescale 1ns/1ps
module test_alrm_monitor;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, q;
    integer fails = 0, comparisons = 0;
    wire [31:0] prdata;
    wire pready, pslverr, force_gen1, advertise_gen2, enter_recovery, retrain_req, bw_irq;
    wire lcrc_error, recovery_entry_local, partner_upgrade_req, full_retrain;
    initial forever #5 pclk = ~pclk;
    alrm_link_model u_link (.pclk(pclk), .lcrc_error(lcrc_error), .full_retrain(full_retrain),
        .recovery_entry_local(recovery_entry_local), .partner_upgrade_req(partner_upgrade_req));
    alrm_monitor #(.US_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lcrc_error(lcrc_error),
        .recovery_entry_local(recovery_entry_local), .partner_upgrade_req(partner_upgrade_req),
        .full_retrain(full_retrain), .force_gen1(force_gen1), .advertise_gen2(advertise_gen2),
        .enter_recovery(enter_recovery), .retrain_req(retrain_req), .bw_irq(bw_irq));
    task chk(input string nm, input [31:0] g, input [31:0] x);
        comparisons = comparisons + 1;
        fails = fails + (g !== x);
        if (g !== x) $display("FAIL %s expected %h seen %h", nm, x, g);
    endtask
    // The master waits on pready with no assumed latency.
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task rdc(input [11:0] a, input [31:0] m, input [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q & m, x);
    endtask
    task complete_run(input integer extra);
        fails = fails + extra;
        $display("%0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial #100000 complete_run(1);
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h000, 32'h3, 32'h0, "ctrl");
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {31'h0, e}, 32'h1);
        apb(1'b1, 12'h004, 32'h00020003);
        apb(1'b1, 12'h010, 32'h1);
        u_link.send(2'd0, 4'd3, 8'd12);
        rdc(12'h00C, 32'hFFFF, 32'h0, "period");
        apb(1'b1, 12'h004, 32'h00000003);
        u_link.send(2'd0, 4'd3, 8'd0);
        rdc(12'h00C, 32'hFFFF, 32'h3, "cnt");
        rdc(12'h008, 32'h1, 32'h0, "sts");
        apb(1'b1, 12'h010, 32'h1);
        rdc(12'h00C, 32'hFFFF, 32'h0, "clr");
        $display("test counting done");
        apb(1'b1, 12'h018, 32'h3);
        apb(1'b1, 12'h010, 32'h2);
        apb(1'b1, 12'h000, 32'h1);
        u_link.send(2'd0, 4'd3, 8'd0);
        u_link.send(2'd2, 4'd1, 8'd0);
        rdc(12'h014, 32'h3, 32'h3, "lsts");
        chk("irq", {31'h0, bw_irq}, 32'h1);
        u_link.send(2'd0, 4'd2, 8'd0);
        rdc(12'h00C, 32'hFFFF, 32'h3, "frz");
        apb(1'b1, 12'h008, 32'h0);
        rdc(12'h008, 32'h1, 32'h1, "stk");
        u_link.send(2'd3, 4'd1, 8'd0);
        rdc(12'h014, 32'h2, 32'h0, "detect");
        $display("test detection done");
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h000, 32'h3);
        u_link.send(2'd1, 4'd3, 8'd0);
        apb(1'b1, 12'h018, 32'h0);
        apb(1'b1, 12'h010, 32'h1);
        rdc(12'h014, 32'h2, 32'h2, "rec");
        $display("test re-arm done");
        complete_run(0);
    end
endmodule
